// ===== rtl/epv_regs.svh
// constants and contract of the eprom program/verify port
//
// Contract
// - programmer enters with straps, then releases clear
// - entry loads boot start address into pc
// - force internal execution, keep code protect
// - boot samples high byte, branch code selects
// - under 72 clocks while clear transitions
// - unused pins float during programming mode
// - high byte pull-ups on in programming
// - test pin high bypasses startup timers
// - address latched on verify strobe rise
// - address load moves to verify itself
// - address load only right after reset
// - verify strobe drives stored word out
// - next verify strobe increments location
// - program strobe in verify starts programming
// - programmer presents data before program strobe
// - data captured three instruction cycles later
// - programming lasts while program strobe high
// - program strobe again reprograms same location
// - verify before program fall: no increment
// - verify after program fall: increment
// - programmer adds triple over-programming pulses
`ifndef EPV_REGS_SVH
`define EPV_REGS_SVH

`define EPV_BOOT_PC 16'hffe0
`define EPV_BRANCH_PV 8'he1
`define EPV_CLK_NS 10
`define EPV_TCY_NS 40
`define EPV_CAPTURE_TCY 3
`define EPV_CAPTURE_CYC \
    ((`EPV_CAPTURE_TCY * `EPV_TCY_NS + `EPV_CLK_NS - 1) / `EPV_CLK_NS)
`define EPV_PULLUP_BYTE 8'hff
`define EPV_FLOAT_BYTE 8'h00
`define EPV_ERASED_WORD 16'hffff
`define EPV_PM_MICROPROC 3'h7
`define EPV_PM_PROTECT 3'h0
`define EPV_POWER_UP_DELAY_TIMER_CYC 16
`define EPV_OST_CYC 16
`define EPV_CNT_W 16
`define EPV_SETUP_CYC 2
`define EPV_SYNC_LAT 8

`endif

// ===== rtl/epv_pkg.sv
// types shared by both ends of the program/verify port
package epv_pkg;

    typedef enum logic [3:0] {
        EPV_D_RESET = 4'h0,
        EPV_D_STARTUP = 4'h1,
        EPV_D_BOOT = 4'h2,
        EPV_D_PARK = 4'h3,
        EPV_D_LOAD = 4'h4,
        EPV_D_VERIFY = 4'h5,
        EPV_D_READ = 4'h6,
        EPV_D_READ_DONE = 4'h7,
        EPV_D_PROG_WAIT = 4'h8,
        EPV_D_PROG_PULSE = 4'h9,
        EPV_D_PROG_END = 4'ha
    } epv_dev_state_t;

    typedef enum logic [2:0] {
        EPV_P_IDLE = 3'h0,
        EPV_P_HOLD = 3'h1,
        EPV_P_BOOT = 3'h2,
        EPV_P_STROBE = 3'h3,
        EPV_P_GAP = 3'h4
    } epv_prg_state_t;

    typedef enum logic [1:0] {
        EPV_CMD_ENTER = 2'h0,
        EPV_CMD_READ = 2'h1,
        EPV_CMD_STEP = 2'h2,
        EPV_CMD_PROGRAM = 2'h3
    } epv_cmd_t;

endpackage

// ===== rtl/epv_if.sv
// pin-level carrier joining the device end and the programmer end
`include "epv_regs.svh"

interface epv_if;
    logic test_pin;
    logic entry_select_a;
    logic entry_select_b;
    logic entry_mode_select;
    logic program_strobe;
    logic address_verify_strobe;
    logic master_clear_n;
    logic [7:0] hb_dev_o;
    logic [7:0] lb_dev_o;
    logic hb_dev_oe;
    logic lb_dev_oe;
    logic hb_pullup_en;
    logic [7:0] hb_prg_o;
    logic [7:0] lb_prg_o;
    logic hb_prg_oe;
    logic lb_prg_oe;
    logic [7:0] high_byte_port;
    logic [7:0] low_byte_port;

    // device drive wins on contention; undriven high byte floats high only while hb_pullup_en is set, else 00
    assign high_byte_port = hb_dev_oe ? hb_dev_o :
                            hb_prg_oe ? hb_prg_o :
                            hb_pullup_en ? `EPV_PULLUP_BYTE : `EPV_FLOAT_BYTE;
    assign low_byte_port = lb_dev_oe ? lb_dev_o :
                           lb_prg_oe ? lb_prg_o : `EPV_FLOAT_BYTE;

    modport dev (
        input test_pin, entry_select_a, entry_select_b, entry_mode_select,
        input program_strobe, address_verify_strobe, master_clear_n,
        input high_byte_port, low_byte_port,
        output hb_dev_o, lb_dev_o, hb_dev_oe, lb_dev_oe, hb_pullup_en
    );

    modport prg (
        output test_pin, entry_select_a, entry_select_b, entry_mode_select,
        output program_strobe, address_verify_strobe, master_clear_n,
        output hb_prg_o, lb_prg_o, hb_prg_oe, lb_prg_oe,
        input high_byte_port, low_byte_port
    );
endinterface

// ===== rtl/epv_sync.sv
// two-flop synchroniser for pin inputs
module epv_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("epv_sync: WIDTH must be at least 1");
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ===== rtl/epv_device.sv
// device end: boot branch and program/verify routine over the pins
`include "epv_regs.svh"

module epv_device import epv_pkg::*; #(
    parameter int MEM_AW = 16,
    parameter int POWER_UP_DELAY_TIMER_CYC = `EPV_POWER_UP_DELAY_TIMER_CYC,
    parameter int OST_CYC = `EPV_OST_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    epv_if.dev pins,
    input wire logic [2:0] fuse_pm,
    input wire logic [7:0] user_out_req,
    input wire logic user_oe_req,
    output logic prog_mode,
    output logic exec_internal,
    output logic code_protect,
    output logic [15:0] pc,
    output logic [7:0] user_out,
    output logic user_oe
);
    localparam int START_CYC = POWER_UP_DELAY_TIMER_CYC + OST_CYC;
    localparam int CAP_CYC = `EPV_CAPTURE_CYC;

    generate
        if (MEM_AW < 1 || MEM_AW > 16) begin : g_chk_aw
            $error("epv_device: MEM_AW must be 1 to 16");
        end
        if (START_CYC < 1 || START_CYC >= (1 << `EPV_CNT_W)) begin : g_chk_t
            $error("epv_device: startup delay out of range");
        end
    endgenerate

    logic [6:0] ctl_s;
    logic [15:0] data_s;
    logic test_s, sel_a_s, sel_b_s, mode_s, ps_s, avs_s, master_clear_n_s;
    logic ps_d_q, avs_d_q;
    logic ps_rise, ps_fall, avs_rise, avs_fall, entry_ok, in_reset;
    epv_dev_state_t st_q;
    logic [`EPV_CNT_W-1:0] cnt_q;
    logic [15:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] mem [0:(1 << MEM_AW)-1];
    logic [15:0] dout_q;
    logic drive_q;
    logic pullup_q;
    logic [MEM_AW-1:0] idx;

    epv_sync #(.WIDTH(7)) u_ctl_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .async_in({pins.test_pin, pins.entry_select_a, pins.entry_select_b,
                   pins.entry_mode_select, pins.program_strobe,
                   pins.address_verify_strobe, pins.master_clear_n}),
        .sync_out(ctl_s)
    );

    epv_sync #(.WIDTH(16)) u_data_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .async_in({pins.high_byte_port, pins.low_byte_port}),
        .sync_out(data_s)
    );

    assign {test_s, sel_a_s, sel_b_s, mode_s, ps_s, avs_s, master_clear_n_s} = ctl_s;
    assign ps_rise = ps_s & ~ps_d_q;
    assign ps_fall = ~ps_s & ps_d_q;
    assign avs_rise = avs_s & ~avs_d_q;
    assign avs_fall = ~avs_s & avs_d_q;
    assign entry_ok = test_s & ~sel_a_s & ~sel_b_s & mode_s;
    // master clear low holds the routine in reset like rst_b does
    assign in_reset = !rst_b || !master_clear_n_s;
    assign idx = addr_q[MEM_AW-1:0];

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ps_d_q <= 1'b0;
            avs_d_q <= 1'b0;
        end else begin
            ps_d_q <= ps_s;
            avs_d_q <= avs_s;
        end
    end

    // straps are caught on the first cycle after clear is released
    always_ff @(posedge mclk) begin
        if (in_reset) begin
            prog_mode <= 1'b0;
        end else if (st_q == EPV_D_RESET) begin
            prog_mode <= entry_ok;
        end
    end

    // main sequencer
    always_ff @(posedge mclk) begin
        if (in_reset) begin
            st_q <= EPV_D_RESET;
            cnt_q <= '0;
        end else begin
            case (st_q)
                EPV_D_RESET: begin
                    cnt_q <= '0;
                    if (entry_ok) begin
                        st_q <= EPV_D_BOOT;
                    end else if (test_s) begin
                        st_q <= EPV_D_PARK;
                    end else begin
                        st_q <= EPV_D_STARTUP;
                    end
                end
                EPV_D_STARTUP: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == `EPV_CNT_W'(START_CYC - 1)) begin
                        st_q <= EPV_D_PARK;
                    end
                end
                EPV_D_BOOT: begin
                    if (data_s[15:8] == `EPV_BRANCH_PV) begin
                        st_q <= EPV_D_LOAD;
                    end else begin
                        st_q <= EPV_D_PARK;
                    end
                end
                EPV_D_LOAD: begin
                    if (avs_rise) begin
                        st_q <= EPV_D_VERIFY;
                    end
                end
                EPV_D_VERIFY: begin
                    if (avs_rise) begin
                        st_q <= EPV_D_READ;
                    end else if (ps_rise) begin
                        st_q <= EPV_D_PROG_WAIT;
                        cnt_q <= '0;
                    end
                end
                EPV_D_READ: begin
                    if (avs_fall) begin
                        st_q <= EPV_D_READ_DONE;
                    end
                end
                EPV_D_READ_DONE: begin
                    if (avs_rise) begin
                        st_q <= EPV_D_VERIFY;
                    end else if (ps_rise) begin
                        st_q <= EPV_D_PROG_WAIT;
                        cnt_q <= '0;
                    end
                end
                EPV_D_PROG_WAIT: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == `EPV_CNT_W'(CAP_CYC - 1)) begin
                        // a strobe already gone ends without a write
                        st_q <= ps_s ? EPV_D_PROG_PULSE : EPV_D_PROG_END;
                    end
                end
                EPV_D_PROG_PULSE: begin
                    if (avs_rise) begin
                        st_q <= EPV_D_VERIFY;
                    end else if (ps_fall) begin
                        st_q <= EPV_D_PROG_END;
                    end
                end
                EPV_D_PROG_END: begin
                    if (ps_rise) begin
                        st_q <= EPV_D_PROG_WAIT;
                        cnt_q <= '0;
                    end else if (avs_rise) begin
                        st_q <= EPV_D_VERIFY;
                    end
                end
                default: begin
                    st_q <= EPV_D_PARK;
                end
            endcase
        end
    end

    // location counter; after programming, a program_strobe rise in the same cycle blocks a verify increment
    always_ff @(posedge mclk) begin
        if (in_reset) begin
            addr_q <= '0;
        end else if (st_q == EPV_D_LOAD && avs_rise) begin
            addr_q <= data_s;
        end else if (st_q == EPV_D_READ_DONE && avs_rise) begin
            addr_q <= addr_q + 1'b1;
        end else if (st_q == EPV_D_PROG_END && avs_rise && !ps_rise) begin
            addr_q <= addr_q + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (in_reset) begin
            pc <= '0;
        end else if (st_q == EPV_D_RESET) begin
            pc <= entry_ok ? `EPV_BOOT_PC : '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (in_reset) begin
            wdata_q <= '0;
        end else if (st_q == EPV_D_PROG_WAIT &&
                     cnt_q == `EPV_CNT_W'(CAP_CYC - 1)) begin
            wdata_q <= data_s;
        end
    end

    // write while strobe high
    // eprom cells only go from one to zero, so each cycle ands in the word;
    // a fresh part comes up erased, master clear alone keeps the cells
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int i = 0; i < (1 << MEM_AW); i++) begin
                mem[i] <= `EPV_ERASED_WORD;
            end
        end else if (!in_reset && st_q == EPV_D_PROG_PULSE && ps_s) begin
            mem[idx] <= mem[idx] & wdata_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (in_reset) begin
            drive_q <= 1'b0;
            dout_q <= '0;
        end else begin
            drive_q <= (st_q == EPV_D_VERIFY && avs_rise) ||
                       (st_q == EPV_D_READ && !avs_fall);
            if (st_q == EPV_D_VERIFY && avs_rise) begin
                dout_q <= mem[idx];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pullup_q <= 1'b0;
        end else begin
            pullup_q <= prog_mode;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            exec_internal <= 1'b1;
            code_protect <= 1'b0;
        end else begin
            exec_internal <= prog_mode || fuse_pm != `EPV_PM_MICROPROC;
            code_protect <= fuse_pm == `EPV_PM_PROTECT;
        end
    end

    always_ff @(posedge mclk) begin
        if (in_reset) begin
            user_oe <= 1'b0;
            user_out <= '0;
        end else begin
            user_oe <= !prog_mode && st_q == EPV_D_PARK && user_oe_req;
            user_out <= user_out_req;
        end
    end

    assign pins.hb_dev_oe = drive_q;
    assign pins.lb_dev_oe = drive_q;
    assign pins.hb_dev_o = dout_q[15:8];
    assign pins.lb_dev_o = dout_q[7:0];
    assign pins.hb_pullup_en = pullup_q;
endmodule

// ===== rtl/epv_programmer.sv
// programmer end: entry sequence, address load, read, step, program
`include "epv_regs.svh"

module epv_programmer import epv_pkg::*; #(
    parameter int HOLD_CYC = 16,
    parameter int BOOT_CYC = 8,
    parameter int STROBE_CYC = 8,
    parameter int GAP_CYC = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    epv_if.prg pins,
    input wire logic cmd_valid,
    input wire epv_cmd_t cmd,
    input wire logic [15:0] cmd_addr,
    input wire logic [15:0] cmd_data,
    input wire logic [15:0] cmd_pulse,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_data
);
    generate
        if (STROBE_CYC < `EPV_SYNC_LAT || GAP_CYC < `EPV_SYNC_LAT ||
            BOOT_CYC < `EPV_SYNC_LAT || HOLD_CYC < 1) begin : g_chk
            $error("epv_programmer: timing parameters too short");
        end
    endgenerate

    epv_prg_state_t st_q;
    epv_cmd_t kind_q;
    logic [15:0] cnt_q;
    logic [15:0] width_q;
    logic [15:0] bus_s;
    logic in_strobe;

    epv_sync #(.WIDTH(16)) u_bus_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .async_in({pins.high_byte_port, pins.low_byte_port}),
        .sync_out(bus_s)
    );

    assign in_strobe = cnt_q >= 16'(`EPV_SETUP_CYC) &&
                       cnt_q < 16'(`EPV_SETUP_CYC) + width_q;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q <= EPV_P_IDLE;
            kind_q <= EPV_CMD_ENTER;
            cnt_q <= '0;
            width_q <= 16'(STROBE_CYC);
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            pins.test_pin <= 1'b0;
            pins.entry_select_a <= 1'b0;
            pins.entry_select_b <= 1'b0;
            pins.entry_mode_select <= 1'b0;
            pins.master_clear_n <= 1'b0;
            pins.program_strobe <= 1'b0;
            pins.address_verify_strobe <= 1'b0;
            pins.hb_prg_o <= '0;
            pins.lb_prg_o <= '0;
            pins.hb_prg_oe <= 1'b0;
            pins.lb_prg_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            cnt_q <= cnt_q + 1'b1;
            case (st_q)
                EPV_P_IDLE: begin
                    cnt_q <= '0;
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        kind_q <= cmd;
                        width_q <= cmd == EPV_CMD_PROGRAM ? cmd_pulse :
                                   16'(STROBE_CYC);
                        // the device floats its ports except during reads
                        pins.hb_prg_oe <= cmd != EPV_CMD_READ;
                        pins.lb_prg_oe <= cmd == EPV_CMD_ENTER ||
                                          cmd == EPV_CMD_PROGRAM;
                        if (cmd == EPV_CMD_ENTER) begin
                            pins.master_clear_n <= 1'b0;
                            pins.test_pin <= 1'b1;
                            pins.entry_select_a <= 1'b0;
                            pins.entry_select_b <= 1'b0;
                            pins.entry_mode_select <= 1'b1;
                            pins.hb_prg_o <= `EPV_BRANCH_PV;
                            st_q <= EPV_P_HOLD;
                        end else begin
                            pins.hb_prg_o <= cmd_data[15:8];
                            pins.lb_prg_o <= cmd_data[7:0];
                            st_q <= EPV_P_STROBE;
                        end
                    end
                end
                EPV_P_HOLD: begin
                    if (cnt_q == 16'(HOLD_CYC - 1)) begin
                        pins.master_clear_n <= 1'b1;
                        cnt_q <= '0;
                        st_q <= EPV_P_BOOT;
                    end
                end
                EPV_P_BOOT: begin
                    if (cnt_q == 16'(BOOT_CYC - 1)) begin
                        pins.hb_prg_o <= cmd_addr[15:8];
                        pins.lb_prg_o <= cmd_addr[7:0];
                        cnt_q <= '0;
                        st_q <= EPV_P_STROBE;
                    end
                end
                EPV_P_STROBE: begin
                    pins.address_verify_strobe <=
                        kind_q != EPV_CMD_PROGRAM && in_strobe;
                    pins.program_strobe <=
                        kind_q == EPV_CMD_PROGRAM && in_strobe;
                    if (kind_q == EPV_CMD_READ &&
                        cnt_q == 16'(`EPV_SETUP_CYC) + width_q - 1'b1) begin
                        rsp_data <= bus_s;
                        rsp_valid <= 1'b1;
                    end
                    if (cnt_q == 16'(`EPV_SETUP_CYC) + width_q) begin
                        cnt_q <= '0;
                        st_q <= EPV_P_GAP;
                    end
                end
                EPV_P_GAP: begin
                    if (cnt_q == 16'(GAP_CYC - 1)) begin
                        pins.hb_prg_oe <= 1'b0;
                        pins.lb_prg_oe <= 1'b0;
                        st_q <= EPV_P_IDLE;
                    end
                end
                default: begin
                    st_q <= EPV_P_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== verif/epv_port_props.sv
// pin-level assertions between the device end and the programmer end
module epv_port_props (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic test_pin,
    input wire logic entry_select_a,
    input wire logic entry_select_b,
    input wire logic entry_mode_select,
    input wire logic program_strobe,
    input wire logic address_verify_strobe,
    input wire logic master_clear_n,
    input wire logic hb_dev_oe,
    input wire logic lb_dev_oe,
    input wire logic hb_prg_oe,
    input wire logic lb_prg_oe,
    input wire logic hb_pullup_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic straps;
    logic [1:0] rises_q;
    assign straps = test_pin && entry_mode_select && !entry_select_a &&
                    !entry_select_b;
    // strobe rises since clear release; saturates so it never wraps to 0
    always_ff @(posedge mclk) begin
        if (!rst_b || !master_clear_n)
            rises_q <= 2'h0;
        else if ($rose(address_verify_strobe) && rises_q != 2'h3)
            rises_q <= rises_q + 2'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_oe_paired: assert property (
        hb_dev_oe == lb_dev_oe) else $error("port enables differ");
    chk_oe_cause: assert property (
        $rose(hb_dev_oe) |-> $past(address_verify_strobe, 3))
        else $error("drive without verify strobe");
    chk_first_load: assert property (
        rises_q < 2'h2 |-> !hb_dev_oe) else $error("address load drove");
    chk_clear_float: assert property (
        !master_clear_n [*6] |-> !hb_dev_oe && !lb_dev_oe)
        else $error("drive while clear low");
    chk_pullup_on: assert property (
        (straps && master_clear_n) [*8] |-> hb_pullup_en)
        else $error("pull-ups off in programming");
    chk_prog_quiet: assert property (
        (program_strobe && !address_verify_strobe) [*8] |-> !hb_dev_oe)
        else $error("device drove during program");
    chk_entry_straps: assert property (
        $rose(master_clear_n) |-> straps) else $error("bad entry straps");
    chk_data_first: assert property (
        $rose(program_strobe) |-> hb_prg_oe && lb_prg_oe)
        else $error("program strobe before data");
    cover property ($rose(hb_dev_oe));
    cover property ($fell(program_strobe));
    cover property ($rose(master_clear_n));
endmodule

// ===== verif/eprom_program_verify_port_bench.sv
// bench: device and programmer joined by the pin carrier
module eprom_program_verify_port_bench import epv_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_b, cmd_valid, cmd_ready, rsp_valid, user_oe_req;
    logic prog_mode, exec_internal, code_protect, user_oe;
    logic [2:0] fuse_pm;
    logic [7:0] user_out_req, user_out;
    logic [15:0] cmd_addr, cmd_data, cmd_pulse, rsp_data, pc, got;
    epv_cmd_t cmd;
    int n_mismatch = 0;
    int checks_done = 0;
    epv_if ifc ();
    epv_device #(.MEM_AW(8)) u_epv_device (.mclk(mclk), .rst_b(rst_b),
        .pins(ifc), .fuse_pm(fuse_pm), .user_out_req(user_out_req),
        .user_oe_req(user_oe_req), .prog_mode(prog_mode),
        .exec_internal(exec_internal), .code_protect(code_protect),
        .pc(pc), .user_out(user_out), .user_oe(user_oe));
    epv_programmer u_epv_programmer (.mclk(mclk), .rst_b(rst_b),
        .pins(ifc), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_pulse(cmd_pulse), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    epv_port_props u_epv_port_props (.mclk(mclk), .rst_b(rst_b),
        .test_pin(ifc.test_pin), .entry_select_a(ifc.entry_select_a),
        .entry_select_b(ifc.entry_select_b),
        .entry_mode_select(ifc.entry_mode_select),
        .program_strobe(ifc.program_strobe),
        .address_verify_strobe(ifc.address_verify_strobe),
        .master_clear_n(ifc.master_clear_n), .hb_dev_oe(ifc.hb_dev_oe),
        .lb_dev_oe(ifc.lb_dev_oe), .hb_prg_oe(ifc.hb_prg_oe),
        .lb_prg_oe(ifc.lb_prg_oe), .hb_pullup_en(ifc.hb_pullup_en));

    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [15:0] exp, logic [15:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one command through the programmer's cmd port; a read answer lands in got
    task automatic run(epv_cmd_t c, logic [15:0] a, logic [15:0] d,
                       logic [15:0] p);
        int n;
        got = 16'hxxxx;
        @(negedge mclk);
        cmd = c;
        cmd_addr = a;
        cmd_data = d;
        cmd_pulse = p;
        cmd_valid = 1'b1;
        for (n = 0; n < 200 && cmd_ready !== 1'b1; n++)
            @(negedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
        for (n = 0; n < 400 && cmd_ready !== 1'b1; n++) begin
            if (rsp_valid === 1'b1)
                got = rsp_data;
            @(negedge mclk);
        end
        if (cmd_ready !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED cmd_ready expected 1 seen %b", cmd_ready);
        end
    endtask

    task automatic t_entry();
        run(EPV_CMD_ENTER, 16'h0010, 16'h0000, 16'h0008);
        chk("pc", 16'hffe0, pc);
        chk("internal", 16'h0001, exec_internal);
        chk("protect", 16'h0000, code_protect);
        chk("prog_mode", 16'h0001, prog_mode);
        chk("user_oe", 16'h0000, user_oe);
        chk("user_out", 16'h005a, user_out);
        chk("hb idle", 16'h00ff, ifc.high_byte_port);
        run(EPV_CMD_READ, 16'h0000, 16'h0000, 16'h0008);
        chk("erased", 16'hffff, got);
    endtask

    task automatic t_program();
        run(EPV_CMD_PROGRAM, 16'h0000, 16'h1234, 16'd20);
        run(EPV_CMD_PROGRAM, 16'h0000, 16'h0ff0, 16'd20);
        // strobe after the program fell: next location, then a read strobe
        run(EPV_CMD_STEP, 16'h0000, 16'h0000, 16'h0008);
        run(EPV_CMD_READ, 16'h0000, 16'h0000, 16'h0008);
        chk("next", 16'hffff, got);
        run(EPV_CMD_PROGRAM, 16'h0000, 16'ha5c3, 16'd20);
    endtask

    task automatic t_reload();
        run(EPV_CMD_ENTER, 16'h0010, 16'h0000, 16'h0008);
        run(EPV_CMD_READ, 16'h0000, 16'h0000, 16'h0008);
        chk("twice", 16'h0230, got);
        // two pulses went in, so six more for margin
        repeat (6) run(EPV_CMD_PROGRAM, 16'h0000, 16'h0230, 16'd20);
        run(EPV_CMD_STEP, 16'h0000, 16'h0000, 16'h0008);
        run(EPV_CMD_READ, 16'h0000, 16'h0000, 16'h0008);
        chk("stepped", 16'ha5c3, got);
    endtask

    // pulse ends before the capture point, so the cell must stay as it was
    task automatic t_short();
        run(EPV_CMD_PROGRAM, 16'h0000, 16'h0000, 16'h0008);
        run(EPV_CMD_ENTER, 16'h0011, 16'h0000, 16'h0008);
        run(EPV_CMD_READ, 16'h0000, 16'h0000, 16'h0008);
        chk("short", 16'ha5c3, got);
        fuse_pm = 3'h0;
        run(EPV_CMD_ENTER, 16'h0011, 16'h0000, 16'h0008);
        chk("internal", 16'h0001, exec_internal);
        chk("protect", 16'h0001, code_protect);
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // the whole run needs well under 1000 cycles
    initial begin
        #50000;
        n_mismatch++;
        $display("CHECK FAILED watchdog expected done seen hang");
        stop_test();
    end

    initial begin
        rst_b = 1'b0;
        cmd_valid = 1'b0;
        cmd = EPV_CMD_ENTER;
        cmd_addr = 16'h0000;
        cmd_data = 16'h0000;
        cmd_pulse = 16'h0008;
        fuse_pm = 3'h7;
        user_out_req = 8'h5a;
        user_oe_req = 1'b1;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        t_entry();
        t_program();
        t_reload();
        t_short();
        stop_test();
    end
endmodule
